/* hw/tdd_power_pkg.sv */
package tdd_power_pkg;

   // Register byte offsets on the AHB-Lite port
   localparam logic [7:0]  OFS_SIGNAL_STRENGTH = 8'h00;
   localparam logic [7:0]  OFS_SOFT_BIAS       = 8'h04;
   localparam logic [7:0]  OFS_MODULATOR       = 8'h08;
   localparam logic [7:0]  OFS_RECEIVER        = 8'h0c;
   localparam logic [7:0]  OFS_AMPLIFIER       = 8'h10;
   localparam logic [7:0]  OFS_CONTROL         = 8'h14;
   localparam logic [7:0]  OFS_STATUS          = 8'h18;

   // Field positions inside the timing registers
   localparam int          POLARITY_BIT        = 15;
   localparam int          ON_FIELD_HI         = 14;
   localparam int          ON_FIELD_LO         = 8;
   localparam int          OFF_FIELD_HI        = 6;
   localparam int          OFF_FIELD_LO        = 0;
   localparam int          BIAS_WIDTH          = 13;

   // Control register bits
   localparam int          CTRL_TX_ENABLE      = 0;
   localparam int          CTRL_FULL_SEARCH    = 1;
   localparam int          CTRL_SOFT_BIAS      = 2;
   localparam int          CTRL_HANDSET        = 3;
   localparam logic [3:0]  CTRL_RESET          = 4'h0;

   // Frame geometry, in bit periods
   localparam logic [9:0]  FRAME_POSITIONS     = 10'h174;
   localparam logic [8:0]  SAMPLE_POSITION     = 9'h048;
   localparam logic [8:0]  MOD_LEN_BASE        = 9'h090;
   localparam logic [8:0]  MOD_LEN_HANDSET     = 9'h094;
   localparam logic [6:0]  ENCODING_OFFSET     = 7'h01;

   // Fixed upper two bits of every 9-bit event position except modulator off
   localparam logic [1:0]  MOD_ON_UP_BASE      = 2'h0;
   localparam logic [1:0]  MOD_ON_UP_HANDSET   = 2'h1;
   localparam logic [1:0]  RX_ON_UP_BASE       = 2'h1;
   localparam logic [1:0]  RX_ON_UP_HANDSET    = 2'h0;
   localparam logic [1:0]  RX_OFF_UP_BASE      = 2'h2;
   localparam logic [1:0]  RX_OFF_UP_HANDSET   = 2'h1;
   localparam logic [1:0]  PA_ON_UP_BASE       = 2'h0;
   localparam logic [1:0]  PA_ON_UP_HANDSET    = 2'h1;
   localparam logic [1:0]  PA_OFF_UP_BASE      = 2'h1;
   localparam logic [1:0]  PA_OFF_UP_HANDSET   = 2'h2;

endpackage

/* hw/tdd_rf_power_timing_ctrl.sv */
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
// Summary of operation
// - Signal-strength register reads latest 8-bit sample, upper byte zero, writes ignored.
// - Sample captured once per frame when receive counter reaches bit 72.
// - Soft bias is a 13-bit two's complement value, 125 Hz steps; reads zero.
// - Soft bias drives the oscillator only while soft-bias select is set.
// - Modulator on field bits 14..8 hold (time mod 128) minus one; reads zero.
// - Modulator position is 9 bits, upper bits 00 base, 01 handset.
// - Modulator switches off 144 bits (base) or 148 bits (handset) after on.
// - Modulator on value acts immediately on write.
// - Modulator held off while transmit enable is clear.
// - Receiver register bit 15 sets front-end pin polarity, 1 active low; reads zero.
// - Receiver on/off fields drive receive power and switch pin on receive counter.
// - Receiver upper bits: on 01/off 10 base, on 00/off 01 handset.
// - Receiver and amplifier time writes act at once.
// - Receive power held on while transmit disabled and full search selected.
// - Amplifier register bit 15 sets amplifier pin polarity, 1 active low; reads zero.
// - Amplifier on/off fields drive amplifier pin on transmit counter, same encoding.
// - Amplifier upper bits: on 00/off 01 base, on 01/off 10 handset.
// - Amplifier pin held inactive while transmit enable is clear.
// - With soft-bias select clear, oscillator takes the loop's own estimate.
module tdd_rf_power_timing_ctrl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [8:0]  tx_frame_count,
   input  wire logic [8:0]  rx_frame_count,
   input  wire logic [7:0]  adc_sample,
   input  wire logic [15:0] afc_bias_estimate,
   output logic [15:0]      nco_bias,
   output logic             modulator_power_on,
   output logic             receiver_power_on,
   output logic             receive_switch_pin,
   output logic             frontend_enable_pin,
   output logic             power_amp_enable_pin
);

   // Reserved upper bits of the bias word are dropped on write
   localparam int BIAS_WIDTH_L = tdd_power_pkg::BIAS_WIDTH;

   logic                    wr_pending_reg;
   logic [7:0]              wr_addr_reg;
   logic [7:0]              signal_strength_value;
   logic [8:0]              rx_count_prev_reg;
   logic [BIAS_WIDTH_L-1:0] soft_bias_reg;
   logic [6:0]              modulator_on_time;
   logic                    frontend_pin_polarity;
   logic [6:0]              receiver_on_time;
   logic [6:0]              receiver_off_time;
   logic                    amplifier_pin_polarity;
   logic [6:0]              amplifier_on_time;
   logic [6:0]              amplifier_off_time;
   logic [3:0]              control_reg;
   logic                    mod_state_reg;
   logic                    rx_state_reg;
   logic                    pa_state_reg;
   logic                    mod_next;
   logic                    rx_next;
   logic                    pa_next;
   logic [8:0]              mod_on_pos;
   logic [8:0]              mod_off_pos;
   logic [8:0]              rx_on_pos;
   logic [8:0]              rx_off_pos;
   logic [8:0]              pa_on_pos;
   logic [8:0]              pa_off_pos;
   logic                    tx_enable;
   logic                    full_search;
   logic                    handset;
   logic                    addr_phase;
   logic                    do_write;
   logic                    sample_now;

   function automatic logic [8:0] frame_add(input logic [8:0] pos, input logic [8:0] len);
      logic [9:0] sum;
      sum = {1'b0, pos} + {1'b0, len};
      if (sum >= tdd_power_pkg::FRAME_POSITIONS) begin
         sum = sum - tdd_power_pkg::FRAME_POSITIONS;
      end
      return sum[8:0];
   endfunction

   function automatic logic [31:0] read_mux(input logic [7:0] addr, input logic [7:0] sig,
                                            input logic [3:0] ctrl, input logic [2:0] st);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (addr)
         tdd_power_pkg::OFS_SIGNAL_STRENGTH: d = {24'h00_0000, sig};
         tdd_power_pkg::OFS_CONTROL:         d = {28'h000_0000, ctrl};
         tdd_power_pkg::OFS_STATUS:          d = {29'h0000_0000, st};
         default:                            d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   assign tx_enable   = control_reg[tdd_power_pkg::CTRL_TX_ENABLE];
   assign full_search = control_reg[tdd_power_pkg::CTRL_FULL_SEARCH];
   assign handset     = control_reg[tdd_power_pkg::CTRL_HANDSET];

   // Freezing the block also stalls the bus so no transfer is lost
   assign hreadyout  = ce;
   assign hresp      = 1'b0;
   assign addr_phase = hsel && htrans[1] && hready;
   assign do_write   = wr_pending_reg && ce;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending_reg <= 1'b0;
         wr_addr_reg    <= 8'h00;
      end else if (ce) begin
         wr_pending_reg <= addr_phase && hwrite;
         wr_addr_reg    <= haddr[7:0];
      end
   end

   // Timing registers are write-only; the mux returns zero for them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ce && addr_phase && !hwrite) begin
         hrdata <= read_mux(haddr[7:0], signal_strength_value, control_reg,
                            {pa_state_reg, rx_state_reg, mod_state_reg});
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_bias_reg          <= 13'h0000;
         modulator_on_time      <= 7'h00;
         frontend_pin_polarity  <= 1'b0;
         receiver_on_time       <= 7'h00;
         receiver_off_time      <= 7'h00;
         amplifier_pin_polarity <= 1'b0;
         amplifier_on_time      <= 7'h00;
         amplifier_off_time     <= 7'h00;
         control_reg            <= tdd_power_pkg::CTRL_RESET;
      end else if (do_write) begin
         unique case (wr_addr_reg)
            tdd_power_pkg::OFS_SOFT_BIAS: begin
               soft_bias_reg <= hwdata[BIAS_WIDTH_L-1:0];
            end
            tdd_power_pkg::OFS_MODULATOR: begin
               modulator_on_time <= hwdata[tdd_power_pkg::ON_FIELD_HI:tdd_power_pkg::ON_FIELD_LO];
            end
            tdd_power_pkg::OFS_RECEIVER: begin
               frontend_pin_polarity <= hwdata[tdd_power_pkg::POLARITY_BIT];
               receiver_on_time      <= hwdata[tdd_power_pkg::ON_FIELD_HI:tdd_power_pkg::ON_FIELD_LO];
               receiver_off_time     <= hwdata[tdd_power_pkg::OFF_FIELD_HI:tdd_power_pkg::OFF_FIELD_LO];
            end
            tdd_power_pkg::OFS_AMPLIFIER: begin
               amplifier_pin_polarity <= hwdata[tdd_power_pkg::POLARITY_BIT];
               amplifier_on_time      <= hwdata[tdd_power_pkg::ON_FIELD_HI:tdd_power_pkg::ON_FIELD_LO];
               amplifier_off_time     <= hwdata[tdd_power_pkg::OFF_FIELD_HI:tdd_power_pkg::OFF_FIELD_LO];
            end
            tdd_power_pkg::OFS_CONTROL: begin
               control_reg <= hwdata[3:0];
            end
            default: begin
               control_reg <= control_reg;
            end
         endcase
      end
   end

   // Capture on arrival at the sample position, once per frame
   assign sample_now = (rx_frame_count == tdd_power_pkg::SAMPLE_POSITION)
                       && (rx_count_prev_reg != tdd_power_pkg::SAMPLE_POSITION);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_count_prev_reg     <= 9'h000;
         signal_strength_value <= 8'h00;
      end else if (ce) begin
         rx_count_prev_reg <= rx_frame_count;
         if (sample_now) begin
            signal_strength_value <= adc_sample;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nco_bias <= 16'h0000;
      end else if (ce) begin
         if (control_reg[tdd_power_pkg::CTRL_SOFT_BIAS]) begin
            nco_bias <= {{(16-BIAS_WIDTH_L){soft_bias_reg[BIAS_WIDTH_L-1]}}, soft_bias_reg};
         end else begin
            nco_bias <= afc_bias_estimate;
         end
      end
   end

   // Positions come straight from the live fields, so writes act at once
   always_comb begin
      mod_on_pos  = {handset ? tdd_power_pkg::MOD_ON_UP_HANDSET : tdd_power_pkg::MOD_ON_UP_BASE,
                     modulator_on_time + tdd_power_pkg::ENCODING_OFFSET};
      mod_off_pos = frame_add(mod_on_pos, handset ? tdd_power_pkg::MOD_LEN_HANDSET
                                                  : tdd_power_pkg::MOD_LEN_BASE);
      rx_on_pos   = {handset ? tdd_power_pkg::RX_ON_UP_HANDSET : tdd_power_pkg::RX_ON_UP_BASE,
                     receiver_on_time + tdd_power_pkg::ENCODING_OFFSET};
      rx_off_pos  = {handset ? tdd_power_pkg::RX_OFF_UP_HANDSET : tdd_power_pkg::RX_OFF_UP_BASE,
                     receiver_off_time + tdd_power_pkg::ENCODING_OFFSET};
      pa_on_pos   = {handset ? tdd_power_pkg::PA_ON_UP_HANDSET : tdd_power_pkg::PA_ON_UP_BASE,
                     amplifier_on_time + tdd_power_pkg::ENCODING_OFFSET};
      pa_off_pos  = {handset ? tdd_power_pkg::PA_OFF_UP_HANDSET : tdd_power_pkg::PA_OFF_UP_BASE,
                     amplifier_off_time + tdd_power_pkg::ENCODING_OFFSET};
   end

   // Off wins when on and off positions coincide
   always_comb begin
      mod_next = mod_state_reg;
      if (!tx_enable) begin
         mod_next = 1'b0;
      end else if (tx_frame_count == mod_off_pos) begin
         mod_next = 1'b0;
      end else if (tx_frame_count == mod_on_pos) begin
         mod_next = 1'b1;
      end
   end

   always_comb begin
      rx_next = rx_state_reg;
      if (!tx_enable && full_search) begin
         rx_next = 1'b1;
      end else if (rx_frame_count == rx_off_pos) begin
         rx_next = 1'b0;
      end else if (rx_frame_count == rx_on_pos) begin
         rx_next = 1'b1;
      end
   end

   always_comb begin
      pa_next = pa_state_reg;
      if (!tx_enable) begin
         pa_next = 1'b0;
      end else if (tx_frame_count == pa_off_pos) begin
         pa_next = 1'b0;
      end else if (tx_frame_count == pa_on_pos) begin
         pa_next = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mod_state_reg        <= 1'b0;
         rx_state_reg         <= 1'b0;
         pa_state_reg         <= 1'b0;
         modulator_power_on   <= 1'b0;
         receiver_power_on    <= 1'b0;
         receive_switch_pin   <= 1'b0;
         frontend_enable_pin  <= 1'b0;
         power_amp_enable_pin <= 1'b0;
      end else if (ce) begin
         mod_state_reg        <= mod_next;
         rx_state_reg         <= rx_next;
         pa_state_reg         <= pa_next;
         modulator_power_on   <= mod_next;
         receiver_power_on    <= rx_next;
         receive_switch_pin   <= rx_next;
         frontend_enable_pin  <= rx_next ^ frontend_pin_polarity;
         power_amp_enable_pin <= pa_next ^ amplifier_pin_polarity;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_mod_held_off: assert property ((ce && !tx_enable) |=> !modulator_power_on)
      else $error("modulator on while transmit disabled");

   a_pa_held_idle: assert property ((ce && !tx_enable) |=>
                                    power_amp_enable_pin == $past(amplifier_pin_polarity))
      else $error("amplifier pin active while transmit disabled");

   a_rx_forced_on: assert property ((ce && !tx_enable && full_search) |=>
                                    (receiver_power_on && receive_switch_pin))
      else $error("receive power not held on in full search");

   a_mod_turn_on: assert property ((ce && tx_enable && tx_frame_count == mod_on_pos
                                    && tx_frame_count != mod_off_pos) |=> modulator_power_on)
      else $error("modulator missed its on position");

   // Off point rebuilt from the package lengths rather than read from mod_off_pos
   a_mod_auto_off: assert property ((ce && tx_enable && mod_state_reg
                                     && tx_frame_count == frame_add(mod_on_pos, handset
                                        ? tdd_power_pkg::MOD_LEN_HANDSET : tdd_power_pkg::MOD_LEN_BASE))
                                    |=> !modulator_power_on)
      else $error("modulator not off after fixed length");

   a_rx_timing: assert property ((ce && tx_enable && rx_frame_count == rx_on_pos
                                  && rx_frame_count != rx_off_pos) |=>
                                 (receiver_power_on && frontend_enable_pin != $past(frontend_pin_polarity)))
      else $error("receiver missed its on position");

   a_rx_turn_off: assert property ((ce && (tx_enable || !full_search)
                                    && rx_frame_count == rx_off_pos) |=> !receiver_power_on)
      else $error("receiver missed its off position");

   a_pa_timing: assert property ((ce && tx_enable && tx_frame_count == pa_off_pos) |=>
                                 power_amp_enable_pin == $past(amplifier_pin_polarity))
      else $error("amplifier pin not idle at off position");

   a_pa_turn_on: assert property ((ce && tx_enable && tx_frame_count == pa_on_pos
                                   && tx_frame_count != pa_off_pos) |=>
                                  power_amp_enable_pin != $past(amplifier_pin_polarity))
      else $error("amplifier pin missed its on position");

   a_strength_capture: assert property ((ce && sample_now) |=>
                                        signal_strength_value == $past(adc_sample))
      else $error("signal strength not captured at sample bit");

   // A counter resting on the sample bit must not recapture every cycle
   a_strength_hold: assert property (!sample_now |=> $stable(signal_strength_value))
      else $error("signal strength changed away from sample bit");

   a_strength_read: assert property ((ce && addr_phase && !hwrite
                                      && haddr[7:0] == tdd_power_pkg::OFS_SIGNAL_STRENGTH) |=>
                                     hrdata == {24'h00_0000, $past(signal_strength_value)})
      else $error("signal strength read value wrong");

   a_wo_reads_zero: assert property ((ce && addr_phase && !hwrite
                                      && (haddr[7:0] == tdd_power_pkg::OFS_SOFT_BIAS
                                       || haddr[7:0] == tdd_power_pkg::OFS_MODULATOR
                                       || haddr[7:0] == tdd_power_pkg::OFS_RECEIVER
                                       || haddr[7:0] == tdd_power_pkg::OFS_AMPLIFIER)) |=>
                                     hrdata == 32'h0000_0000)
      else $error("write-only register read nonzero");

   a_bias_select: assert property ((ce && control_reg[tdd_power_pkg::CTRL_SOFT_BIAS]) |=>
                                   nco_bias == {{3{$past(soft_bias_reg[12])}}, $past(soft_bias_reg)})
      else $error("soft bias not applied");

   a_bias_loop: assert property ((ce && !control_reg[tdd_power_pkg::CTRL_SOFT_BIAS]) |=>
                                 nco_bias == $past(afc_bias_estimate))
      else $error("loop estimate not applied");

   a_bias_write: assert property ((do_write && wr_addr_reg == tdd_power_pkg::OFS_SOFT_BIAS) |=>
                                  soft_bias_reg == $past(hwdata[BIAS_WIDTH_L-1:0]))
      else $error("soft bias write lost");

   a_mod_write: assert property ((do_write && wr_addr_reg == tdd_power_pkg::OFS_MODULATOR) |=>
                                 modulator_on_time == $past(hwdata[tdd_power_pkg::ON_FIELD_HI:tdd_power_pkg::ON_FIELD_LO]))
      else $error("modulator on time write lost");

   a_pa_pol_write: assert property ((do_write && wr_addr_reg == tdd_power_pkg::OFS_AMPLIFIER) |=>
                                    amplifier_pin_polarity == $past(hwdata[tdd_power_pkg::POLARITY_BIT]))
      else $error("amplifier polarity write lost");

   a_rx_pol_write: assert property ((do_write && wr_addr_reg == tdd_power_pkg::OFS_RECEIVER) |=>
                                    frontend_pin_polarity == $past(hwdata[tdd_power_pkg::POLARITY_BIT]))
      else $error("front-end polarity write lost");

   // Fixed upper bits depend only on the station role
   a_mod_upper: assert property (mod_on_pos[8:7] == (handset ? 2'b01 : 2'b00))
      else $error("modulator upper bits wrong");

   a_rx_upper: assert property ((rx_on_pos[8:7] == (handset ? 2'b00 : 2'b01))
                                && (rx_off_pos[8:7] == (handset ? 2'b01 : 2'b10)))
      else $error("receiver upper bits wrong");

   a_pa_upper: assert property ((pa_on_pos[8:7] == (handset ? 2'b01 : 2'b00))
                                && (pa_off_pos[8:7] == (handset ? 2'b10 : 2'b01)))
      else $error("amplifier upper bits wrong");

endmodule

/* tb/rf_module_model.sv */
`timescale 1ns/100ps
module rf_module_model #(
   parameter logic [15:0] AFC_EST = 16'hfc18
) (
   input  wire logic        hclk,
   input  wire logic        power_amp_enable_pin,
   input  wire logic        receive_switch_pin,
   input  wire logic        frontend_enable_pin,
   output logic      [7:0]  adc_sample,
   output logic      [15:0] afc_bias_estimate
);
   // Detector level is dialled in by the bench; held steady so one capture is unambiguous
   logic [7:0] level;
   logic       pa_prev;
   int         pa_toggles;

   initial level = 8'h00;
   initial pa_prev = 1'b0;
   initial pa_toggles = 0;
   assign adc_sample        = level;
   assign afc_bias_estimate = AFC_EST;

   // Keying activity seen by the transmitter
   always @(posedge hclk) begin
      pa_prev <= power_amp_enable_pin;
      if (power_amp_enable_pin !== pa_prev)
         pa_toggles <= pa_toggles + 1;
   end
endmodule

/* tb/tdd_rf_power_timing_ctrl_tb.sv */
`timescale 1ns/100ps
module tdd_rf_power_timing_ctrl_tb;
   localparam logic [15:0] AFC = 16'hfc18;
   logic        hclk, hresetn, ce, hsel, hwrite, hresp, hreadyout;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [8:0]  tx, rx;
   logic [7:0]  adc;
   logic [15:0] afc, nco;
   logic        mod, rxp, sw, fe, pa;
   int          mismatches, checks;

   tdd_rf_power_timing_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_frame_count(tx), .rx_frame_count(rx),
      .adc_sample(adc), .afc_bias_estimate(afc), .nco_bias(nco), .modulator_power_on(mod),
      .receiver_power_on(rxp), .receive_switch_pin(sw), .frontend_enable_pin(fe),
      .power_amp_enable_pin(pa));

   rf_module_model #(.AFC_EST(AFC)) rf (.hclk(hclk), .power_amp_enable_pin(pa),
      .receive_switch_pin(sw), .frontend_enable_pin(fe), .adc_sample(adc), .afc_bias_estimate(afc));

   always #25 hclk = ~hclk;

   task automatic results();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Single word transfer; a stuck slave is left to the watchdog
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      d = hrdata;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, rd);
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      ahb(1'b0, a, 32'h0, d);
   endtask

   // Counters held two edges so both state and pin have settled
   task automatic at(input logic [8:0] t, input logic [8:0] r);
      @(posedge hclk);
      tx <= t;
      rx <= r;
      repeat (2) @(posedge hclk);
      @(negedge hclk);
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      results();
   end

   initial begin
      logic [7:0]  ofs [6];
      logic [8:0]  mon, moff, pon, poff, ron, roff;
      hclk = 0;
      hresetn = 0;
      ce = 1;
      hsel = 0;
      haddr = 0;
      htrans = 0;
      hwrite = 0;
      hsize = 3'h2;
      hwdata = 0;
      tx = 0;
      rx = 0;
      mismatches = 0;
      checks = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      cmp_bit("pa reset", 1'b0, pa);
      cmp_bit("hresp", 1'b0, hresp);
      ofs = '{tdd_power_pkg::OFS_SIGNAL_STRENGTH, tdd_power_pkg::OFS_SOFT_BIAS, tdd_power_pkg::OFS_MODULATOR,
              tdd_power_pkg::OFS_RECEIVER, tdd_power_pkg::OFS_AMPLIFIER, 8'h1c};
      foreach (ofs[i]) begin
         reg_write(ofs[i], 32'hffff_ffff);
         reg_read(ofs[i], rd);
         cmp_word("readback", 32'h0, rd);
      end
      reg_write(tdd_power_pkg::OFS_SOFT_BIAS, 32'h0000_f000);
      reg_write(tdd_power_pkg::OFS_CONTROL, 32'h4);
      at(0, 0);
      cmp_word("bias neg", 32'h0000_f000, {16'h0, nco});
      reg_write(tdd_power_pkg::OFS_SOFT_BIAS, 32'h0000_e0ff);
      at(0, 0);
      cmp_word("bias pos", 32'h0000_00ff, {16'h0, nco});
      reg_write(tdd_power_pkg::OFS_CONTROL, 32'h0);
      at(0, 0);
      cmp_word("bias loop", {16'h0, AFC}, {16'h0, nco});
      rf.level <= 8'ha5;
      at(0, 71);
      at(0, 72);
      rf.level <= 8'h3c;
      at(0, 72);
      reg_read(tdd_power_pkg::OFS_SIGNAL_STRENGTH, rd);
      cmp_word("sample", 32'h0000_00a5, rd);
      at(0, 73);
      at(0, 72);
      reg_read(tdd_power_pkg::OFS_SIGNAL_STRENGTH, rd);
      cmp_word("sample next", 32'h0000_003c, rd);
      for (int hs = 0; hs < 2; hs++) begin
         reg_write(tdd_power_pkg::OFS_CONTROL, hs[0] ? 32'h9 : 32'h1);
         reg_write(tdd_power_pkg::OFS_MODULATOR, 32'h0000_7f00);
         reg_write(tdd_power_pkg::OFS_RECEIVER, 32'h0000_0404);
         reg_write(tdd_power_pkg::OFS_AMPLIFIER, 32'h0000_0909);
         mon = {hs[0] ? 2'b01 : 2'b00, 7'h00};
         moff = 9'((mon + (hs[0] ? 148 : 144)) % 372);
         pon = {hs[0] ? 2'b01 : 2'b00, 7'h0a};
         poff = {hs[0] ? 2'b10 : 2'b01, 7'h0a};
         ron = {hs[0] ? 2'b00 : 2'b01, 7'h05};
         roff = {hs[0] ? 2'b01 : 2'b10, 7'h05};
         at(moff, roff);
         cmp_bit("mod idle", 1'b0, mod);
         at(mon, roff);
         cmp_bit("mod on", 1'b1, mod);
         at(moff - 9'd1, roff);
         cmp_bit("mod hold", 1'b1, mod);
         at(moff, roff);
         cmp_bit("mod off", 1'b0, mod);
         reg_write(tdd_power_pkg::OFS_MODULATOR, 32'h0000_0000);
         at(mon + 9'd1, roff);
         cmp_bit("mod moved", 1'b1, mod);
         at(poff, ron);
         cmp_bit("rx on", 1'b1, rxp);
         cmp_bit("sw on", 1'b1, sw);
         cmp_bit("fe on", 1'b1, fe);
         at(poff, roff);
         cmp_bit("rx off", 1'b0, rxp);
         at(pon, roff);
         cmp_bit("pa on", 1'b1, pa);
         at(poff, roff);
         cmp_bit("pa off", 1'b0, pa);
         reg_write(tdd_power_pkg::OFS_AMPLIFIER, 32'h0000_0a09);
         at(pon + 9'd1, roff);
         cmp_bit("pa moved", 1'b1, pa);
         at(poff, roff);
      end
      reg_write(tdd_power_pkg::OFS_RECEIVER, 32'h0000_8404);
      reg_write(tdd_power_pkg::OFS_AMPLIFIER, 32'h0000_8909);
      at(0, 0);
      cmp_bit("fe idle low", 1'b1, fe);
      cmp_bit("pa idle low", 1'b1, pa);
      at(9'd138, 0);
      cmp_bit("pa active low", 1'b0, pa);
      reg_write(tdd_power_pkg::OFS_CONTROL, 32'h8);
      at(9'd138, 0);
      cmp_bit("pa disabled", 1'b1, pa);
      at(9'd129, 0);
      cmp_bit("mod disabled", 1'b0, mod);
      reg_write(tdd_power_pkg::OFS_CONTROL, 32'ha);
      at(0, 0);
      cmp_bit("rx forced", 1'b1, rxp);
      cmp_bit("fe forced", 1'b0, fe);
      reg_read(tdd_power_pkg::OFS_CONTROL, rd);
      cmp_word("control", 32'h0000_000a, rd);
      reg_read(tdd_power_pkg::OFS_STATUS, rd);
      cmp_word("status forced", 32'h0000_0002, rd);
      cmp_bit("pa keyed", 1'b1, rf.pa_toggles > 0);
      results();
   end
endmodule
